/* File: logic/lbgc_pkg.sv */
/*
 * Package for the bank-wide configuration block of a 16-channel line interface.
 * Holds register offsets, field positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and an 8-bit host register port with a 6-bit address.
 */
package lbgc_pkg;
	localparam int          ADDR_W            = 6;
	localparam int          DATA_W            = 8;
	localparam int          NUM_CH            = 16;
	localparam int          BANK_CH           = 8;

	// Register offsets
	localparam logic [5:0]  OFS_AAOS_LOWER    = 6'h0e;
	localparam logic [5:0]  OFS_GCFG_LOWER    = 6'h0f;
	localparam logic [5:0]  OFS_TSEL_LOWER    = 6'h10;
	localparam logic [5:0]  OFS_AAOS_UPPER    = 6'h2e;
	localparam logic [5:0]  OFS_GCFG_UPPER    = 6'h2f;
	localparam logic [5:0]  OFS_TSEL_UPPER    = 6'h30;
	localparam logic [7:0]  REG_RESET         = 8'h00;

	// Global configuration fields
	localparam int          GC_RX_MODE        = 7;
	localparam int          GC_ALARM_LOSS     = 6;
	localparam int          GC_SHORT_DIS      = 5;
	localparam int          GC_AMI            = 4;
	localparam int          GC_DEPTH          = 3;
	localparam int          GC_CAL            = 2;
	localparam int          GC_POSITION       = 1;
	localparam int          GC_ATTEN_EN       = 0;

	// Template target select fields
	localparam int          TS_BW_HI          = 7;
	localparam int          TS_BW_LO          = 6;
	localparam int          TS_HITLESS        = 5;
	localparam int          TS_PTR_HI         = 2;
	localparam int          TS_PTR_LO         = 0;
	localparam logic [3:0]  UPPER_BASE        = 4'h8;

	// Calibration timing: trigger runs a fixed cycle of this length
	localparam int          CAL_TIME_US       = 5;
	localparam int          CLK_MHZ           = 50;
	localparam int          CAL_CYCLES        = CAL_TIME_US * CLK_MHZ;
	localparam logic [8:0]  CAL_COUNT         = 9'(CAL_CYCLES);

	typedef enum logic [1:0] {
		LBGC_BW_0P625,
		LBGC_BW_1P25,
		LBGC_BW_2P5,
		LBGC_BW_5
	} lbgc_bw_t;

	typedef enum {
		LBGC_CAL_IDLE,
		LBGC_CAL_RUN,
		LBGC_CAL_DONE
	} lbgc_cal_state_t;

	// Host register access strobes
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [7:0]  wdata;
	} lbgc_host_req_t;

	// Per-channel settings from the individual registers
	typedef struct packed {
		logic [15:0] alarm_on_loss;
		logic [15:0] short_disable;
		logic [15:0] line_code_ami;
		logic [15:0] depth_deep;
		logic [15:0] atten_position;
		logic [15:0] atten_enable;
		logic [15:0] rx_match_on;
	} lbgc_chan_cfg_t;
endpackage

/* File: logic/lbgc_bank_global_config.sv */
/*
 * Bank-wide configuration registers for both channel banks, the effective
 * per-channel controls derived from them, and the termination calibration
 * handshake. Each global bit except the calibration and mode bits either forces its per-channel
 * control for the eight channels of its bank or leaves that control to the per-channel input.
 * Assumes the host port logic is on the same clock and that loss and
 * output-enable come from pins, so those pass a two-stage synchroniser.
 * The per-channel settings arrive as levels from the individual register
 * banks on this clock and are used without synchronisation. The calibration
 * cycle is a fixed count standing in for the analog trim; a real trim engine
 * would replace the counter and keep the same handshake.
 */
`timescale 1ns/100ps

// Functional notes
// [R1] Channel with all-ones select set sends all ones while losing signal.
// [R2] Lower global register: calibrate trigger covers all channels, others channels 1-8.
// [R3] Upper global register: calibration enable covers all, others channels 9-16.
// [R4] Mode bit set gives internal termination, else external trimmed when match on.
// [R5] Global alarm-on-loss bit overrides per-channel alarm settings for its bank.
// [R6] Global short-protect disable overrides per-channel disable settings for its bank.
// [R7] Global coding bit forces AMI on bank channels, overriding line code.
// [R8] Global depth bit forces deep attenuator FIFO, overriding per-channel depth.
// [R9] Each rising write of the calibrate trigger starts one calibration cycle; here a rising write during a run is ignored.
// [R10] Trigger acts only while calibration enable is set in upper register.
// [R11] While trigger stays set, calibration status is reported per channel bank; here one cal_status bit serves both banks.
// [R12] Software waits 5 us after enabling calibration before triggering.
// [R13] Position bit picks receive or transmit path; per-channel overrides unless enable.
// [R14] Global attenuator enable overrides per-channel enable settings for its bank.
// [R15] Two-bit bandwidth code selects one of four E1 attenuator bandwidths.
// [R16] Hitless bit hands receive matching to output-enable pin, else match bit.
// [R17] Three-bit pointer picks which bank channel the template register configures.
// [R18] Pointer k selects channel k+1 in lower bank, k+9 in upper.
// [R19] Match-on bit enables internal receive matching, else receiver high impedance.
// [R20] Registers reset to zero and read back the last written value.
module lbgc_bank_global_config
	import lbgc_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  clk_en,
	input  wire lbgc_host_req_t        host_req,
	output logic [7:0]                 host_rdata,
	output logic                       host_rvalid,
	input  wire logic [15:0]           loss_detect,
	input  wire logic                  output_enable_pin,
	input  wire lbgc_chan_cfg_t        chan_cfg,
	output logic [15:0]                send_all_ones,
	output logic [15:0]                send_alarm_sys,
	output logic [15:0]                short_protect_off,
	output logic [15:0]                ami_select,
	output logic [15:0]                atten_deep,
	output logic [15:0]                atten_in_rx,
	output logic [15:0]                atten_on,
	output logic [15:0]                rx_match_active,
	output logic [15:0]                rx_internal_term,
	output logic [1:0]                 bw_code_lower,
	output logic [1:0]                 bw_code_upper,
	output logic [3:0]                 template_channel_lower,
	output logic [4:0]                 template_channel_upper,
	output logic                       cal_running,
	output logic                       cal_status
);

	// Host-visible registers, one set per bank
	logic [7:0]        aaos_lower_q;
	logic [7:0]        aaos_upper_q;
	logic [7:0]        gcfg_lower_q;
	logic [7:0]        gcfg_upper_q;
	logic [7:0]        tsel_lower_q;
	logic [7:0]        tsel_upper_q;

	// Two-stage synchronisers; the first stage may go metastable
	logic [15:0]       loss_meta_q;
	logic [15:0]       loss_sync_q;
	logic              oe_meta_q;
	logic              oe_sync_q;

	// Calibration sequencer state and run counter
	lbgc_cal_state_t   cal_state_q;
	lbgc_cal_state_t   cal_state_d;
	logic [8:0]        cal_cnt_q;
	logic [8:0]        cal_cnt_d;

	// Address decode of the host write and read strobes
	// Writes to any other offset are ignored
	wire         wr_aaos_lower = host_req.wr && host_req.addr == OFS_AAOS_LOWER;
	wire         wr_aaos_upper = host_req.wr && host_req.addr == OFS_AAOS_UPPER;
	wire         wr_gcfg_lower = host_req.wr && host_req.addr == OFS_GCFG_LOWER;
	wire         wr_gcfg_upper = host_req.wr && host_req.addr == OFS_GCFG_UPPER;
	wire         wr_tsel_lower = host_req.wr && host_req.addr == OFS_TSEL_LOWER;
	wire         wr_tsel_upper = host_req.wr && host_req.addr == OFS_TSEL_UPPER;

	// Unmapped offsets read as zero so software sees no stale value
	// [R20] plain readback
	wire [7:0]   rd_mux =
		(host_req.addr == OFS_AAOS_LOWER) ? aaos_lower_q :
		(host_req.addr == OFS_AAOS_UPPER) ? aaos_upper_q :
		(host_req.addr == OFS_GCFG_LOWER) ? gcfg_lower_q :
		(host_req.addr == OFS_GCFG_UPPER) ? gcfg_upper_q :
		(host_req.addr == OFS_TSEL_LOWER) ? tsel_lower_q :
		(host_req.addr == OFS_TSEL_UPPER) ? tsel_upper_q : REG_RESET;

	// The edge is judged against the stored bit, so rewriting a 1 does nothing
	// [R9] rising trigger write
	wire         trig_rise = wr_gcfg_lower && host_req.wdata[GC_CAL] && !gcfg_lower_q[GC_CAL];
	// [R2] trigger is chip-wide
	wire         trig_held = gcfg_lower_q[GC_CAL];
	// [R3] enable is chip-wide
	// Without the enable a rising trigger is dropped, not held for later
	// [R10] gate on enable
	wire         cal_start = trig_rise && gcfg_upper_q[GC_CAL];

	// Pointer fields of the lower and upper template select registers
	wire [2:0]   ptr_lower = tsel_lower_q[TS_PTR_HI:TS_PTR_LO];
	wire [2:0]   ptr_upper = tsel_upper_q[TS_PTR_HI:TS_PTR_LO];

	// Lower bank registers; all reset to zero
	always_ff @(posedge clock) begin
		if (srst) begin
			aaos_lower_q <= REG_RESET;
			gcfg_lower_q <= REG_RESET;
			tsel_lower_q <= REG_RESET;
		end else if (clk_en) begin
			if (wr_aaos_lower) aaos_lower_q <= host_req.wdata;
			if (wr_gcfg_lower) gcfg_lower_q <= host_req.wdata;
			if (wr_tsel_lower) tsel_lower_q <= host_req.wdata;
		end
	end

	// Upper bank registers; the calibration enable in here serves both banks
	always_ff @(posedge clock) begin
		if (srst) begin
			aaos_upper_q <= REG_RESET;
			gcfg_upper_q <= REG_RESET;
			tsel_upper_q <= REG_RESET;
		end else if (clk_en) begin
			if (wr_aaos_upper) aaos_upper_q <= host_req.wdata;
			if (wr_gcfg_upper) gcfg_upper_q <= host_req.wdata;
			if (wr_tsel_upper) tsel_upper_q <= host_req.wdata;
		end
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge clock) begin
		if (srst) begin
			host_rdata  <= REG_RESET;
			host_rvalid <= 1'b0;
		end else if (clk_en) begin
			host_rvalid <= host_req.rd;
			host_rdata  <= host_req.rd ? rd_mux : REG_RESET;
		end
	end

	// Loss levels pass two flops; only the second stage is read
	always_ff @(posedge clock) begin
		if (srst) begin
			loss_meta_q <= 16'h0000;
			loss_sync_q <= 16'h0000;
		end else if (clk_en) begin
			loss_meta_q <= loss_detect;
			loss_sync_q <= loss_meta_q;
		end
	end

	// Output-enable pin takes the same two-flop path
	always_ff @(posedge clock) begin
		if (srst) begin
			oe_meta_q <= 1'b0;
			oe_sync_q <= 1'b0;
		end else if (clk_en) begin
			oe_meta_q <= output_enable_pin;
			oe_sync_q <= oe_meta_q;
		end
	end

	// Calibration sequencer; the cycle length stands in for the analog trim
	// IDLE waits for an enabled rising trigger, RUN counts the fixed cycle,
	// DONE holds status until the trigger is cleared or rewritten from zero
	always_comb begin
		cal_state_d = cal_state_q;
		cal_cnt_d   = cal_cnt_q;
		case (cal_state_q)
			LBGC_CAL_IDLE: begin
				if (cal_start) begin
					cal_state_d = LBGC_CAL_RUN;
					cal_cnt_d   = CAL_COUNT;
				end
			end
			LBGC_CAL_RUN: begin
				// Leave on the last count so the run lasts exactly CAL_COUNT cycles
				if (cal_cnt_q == 9'h001) begin
					cal_state_d = LBGC_CAL_DONE;
				end
				cal_cnt_d = cal_cnt_q - 9'h001;
			end
			LBGC_CAL_DONE: begin
				// A new rising trigger restarts; clearing the trigger rearms
				if (cal_start) begin
					cal_state_d = LBGC_CAL_RUN;
					cal_cnt_d   = CAL_COUNT;
				end else if (!trig_held) begin
					cal_state_d = LBGC_CAL_IDLE;
				end
			end
			// Unreachable encodings fall back to idle
			default: begin
				cal_state_d = LBGC_CAL_IDLE;
				cal_cnt_d   = 9'h000;
			end
		endcase
	end

	// Sequencer registers, frozen with the rest while the clock enable is low
	always_ff @(posedge clock) begin
		if (srst) begin
			cal_state_q <= LBGC_CAL_IDLE;
			cal_cnt_q   <= 9'h000;
		end else if (clk_en) begin
			cal_state_q <= cal_state_d;
			cal_cnt_q   <= cal_cnt_d;
		end
	end

	// Per-channel effective controls, one generate lane per channel
	// Lanes 0-7 take the lower bank registers, lanes 8-15 the upper
	logic [15:0] all_ones_d;
	logic [15:0] alarm_d;
	logic [15:0] short_d;
	logic [15:0] ami_d;
	logic [15:0] deep_d;
	logic [15:0] rxpos_d;
	logic [15:0] aen_d;
	logic [15:0] match_d;
	logic [15:0] iterm_d;

	// The bank of a lane is fixed at elaboration, so the bank selects cost no logic
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			localparam bit UP = (ch >= BANK_CH);
			// The modulo keeps both select indices inside the 8-bit registers
			wire [7:0] gc  = UP ? gcfg_upper_q : gcfg_lower_q;
			wire [7:0] ts  = UP ? tsel_upper_q : tsel_lower_q;
			wire       sel = UP ? aaos_upper_q[ch % BANK_CH] : aaos_lower_q[ch % BANK_CH];
			// Global enable also pins the position to the global setting
			wire       atten_global = gc[GC_ATTEN_EN];
			// [R19] match bit governs
			// [R16] hitless hands matching to pin
			wire       match_on = ts[TS_HITLESS] ? oe_sync_q : chan_cfg.rx_match_on[ch];
			// Loss is the synced level, so requests lag the pin by three edges
			// [R1] all ones on loss
			assign all_ones_d[ch] = sel && loss_sync_q[ch];
			// AIS goes only where loss is seen, even under the global bit
			// [R5] alarm override
			assign alarm_d[ch] = loss_sync_q[ch] &&
				(gc[GC_ALARM_LOSS] || chan_cfg.alarm_on_loss[ch]);
			// [R6] short-protect override
			assign short_d[ch] = gc[GC_SHORT_DIS] || chan_cfg.short_disable[ch];
			// [R7] AMI override
			assign ami_d[ch] = gc[GC_AMI] || chan_cfg.line_code_ami[ch];
			// [R8] depth override
			assign deep_d[ch] = gc[GC_DEPTH] || chan_cfg.depth_deep[ch];
			// [R14] enable override
			assign aen_d[ch] = atten_global || chan_cfg.atten_enable[ch];
			// [R13] position, per-channel ignored under global enable
			assign rxpos_d[ch] = atten_global ? gc[GC_POSITION] :
				(gc[GC_POSITION] || chan_cfg.atten_position[ch]);
			// Matching follows the synced pin only under hitless control
			assign match_d[ch] = match_on;
			// Internal termination follows the mode bit alone; matching does not gate it or the calibration
			// [R4] termination mode
			assign iterm_d[ch] = gc[GC_RX_MODE];
		end
	endgenerate

	// [R17] pointer picks target
	// [R18] pointer to channel number
	// The upper sum needs five bits: pointer 7 lands on channel 16
	wire [3:0] tgt_lower = {1'b0, ptr_lower} + 4'h1;
	wire [4:0] tgt_upper = {2'b00, ptr_upper} + {1'b0, UPPER_BASE} + 5'h01;

	// Loss-driven and override outputs; every port comes from a flop
	always_ff @(posedge clock) begin
		if (srst) begin
			send_all_ones     <= 16'h0000;
			send_alarm_sys    <= 16'h0000;
			short_protect_off <= 16'h0000;
			ami_select        <= 16'h0000;
			atten_deep        <= 16'h0000;
		end else if (clk_en) begin
			send_all_ones     <= all_ones_d;
			send_alarm_sys    <= alarm_d;
			short_protect_off <= short_d;
			ami_select        <= ami_d;
			atten_deep        <= deep_d;
		end
	end

	// Attenuator placement and receive termination outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			atten_in_rx      <= 16'h0000;
			atten_on         <= 16'h0000;
			rx_match_active  <= 16'h0000;
			rx_internal_term <= 16'h0000;
		end else if (clk_en) begin
			atten_in_rx      <= rxpos_d;
			atten_on         <= aen_d;
			rx_match_active  <= match_d;
			rx_internal_term <= iterm_d;
		end
	end

	// Bandwidth codes and template targets; reset points at each bank's first channel
	always_ff @(posedge clock) begin
		if (srst) begin
			bw_code_lower          <= 2'h0;
			bw_code_upper          <= 2'h0;
			template_channel_lower <= 4'h1;
			template_channel_upper <= 5'h09;
		end else if (clk_en) begin
			// [R15] bandwidth code out
			bw_code_lower          <= tsel_lower_q[TS_BW_HI:TS_BW_LO];
			bw_code_upper          <= tsel_upper_q[TS_BW_HI:TS_BW_LO];
			template_channel_lower <= tgt_lower;
			template_channel_upper <= tgt_upper;
		end
	end

	// Calibration flags; status drops the cycle after software clears the trigger
	always_ff @(posedge clock) begin
		if (srst) begin
			cal_running <= 1'b0;
			cal_status  <= 1'b0;
		end else if (clk_en) begin
			cal_running <= cal_state_q == LBGC_CAL_RUN;
			// [R11] status while trigger held
			cal_status  <= trig_held && cal_state_q == LBGC_CAL_DONE;
		end
	end

endmodule

/* File: testbench/lbgc_chk.sv */
/* Checker for the bank configuration block.
   Sees only the design's ports; bound from tb_top with clk_en held high. */
`timescale 1ns/100ps
module lbgc_chk
	import lbgc_pkg::*;
(
	input wire logic           clock,
	input wire logic           srst,
	input wire logic           clk_en,
	input wire lbgc_host_req_t host_req,
	input wire logic [7:0]     host_rdata,
	input wire logic           host_rvalid,
	input wire logic [15:0]    loss_detect,
	input wire logic           output_enable_pin,
	input wire lbgc_chan_cfg_t chan_cfg,
	input wire logic [15:0]    send_all_ones,
	input wire logic [15:0]    send_alarm_sys,
	input wire logic [3:0]     template_channel_lower,
	input wire logic [4:0]     template_channel_upper,
	input wire logic           cal_running,
	input wire logic           cal_status
);
	logic [8:0] run_q;
	wire        mapped = host_req.addr inside {OFS_AAOS_LOWER, OFS_GCFG_LOWER,
		OFS_TSEL_LOWER, OFS_AAOS_UPPER, OFS_GCFG_UPPER, OFS_TSEL_UPPER};

	// Counts the current calibration run so its length can be judged
	always_ff @(posedge clock) begin
		if (srst) run_q <= 9'h000;
		else run_q <= cal_running ? run_q + 9'h001 : 9'h000;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	a_rvalid_after_rd: assert property (host_req.rd |=> host_rvalid)
		else $error("read strobe not answered");
	a_rdata_idle: assert property (!host_req.rd |=> !host_rvalid && host_rdata == 8'h00)
		else $error("read data without a read");
	a_unmapped_zero: assert property (host_req.rd && !mapped |=> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_tpl_lower_range: assert property (template_channel_lower inside {[4'h1:4'h8]})
		else $error("lower template channel out of bank");
	a_tpl_upper_range: assert property (template_channel_upper inside {[5'h09:5'h10]})
		else $error("upper template channel out of bank");
	a_cal_length: assert property ($fell(cal_running) && !$past(srst) |->
		run_q == 9'(CAL_CYCLES))
		else $error("calibration run length wrong");
	a_status_not_running: assert property (cal_status |-> !cal_running)
		else $error("status while still running");
	a_all_ones_loss: assert property ((send_all_ones & ~$past(loss_detect, 3)) == 16'h0000)
		else $error("all ones without loss");
	a_alarm_loss: assert property ((send_alarm_sys & ~$past(loss_detect, 3)) == 16'h0000)
		else $error("alarm without loss");

	// Main scenarios reached
	c_cal_done: cover property ($rose(cal_status));
	c_all_ones: cover property (send_all_ones != 16'h0000);
	c_unmapped: cover property (host_req.rd && !mapped);
	c_alarm: cover property (send_alarm_sys != 16'h0000);
endmodule

/* File: testbench/tb_top.sv */
/* Testbench for the bank configuration block: register access, overrides,
   pointer and calibration sequences. Assumes the package is compiled first. */
`timescale 1ns/100ps
module tb_top
	import lbgc_pkg::*;
;
	logic           clock = 1'b0;
	logic           srst = 1'b1;
	logic           clk_en = 1'b1;
	lbgc_host_req_t host_req = '0;
	logic [15:0]    loss_detect = 16'h0000;
	logic           output_enable_pin = 1'b0;
	lbgc_chan_cfg_t chan_cfg = '0;
	logic [7:0]     host_rdata;
	logic           host_rvalid, cal_running, cal_status;
	logic [15:0]    send_all_ones, send_alarm_sys, short_protect_off, ami_select;
	logic [15:0]    atten_deep, atten_in_rx, atten_on, rx_match_active, rx_internal_term;
	logic [1:0]     bw_code_lower, bw_code_upper;
	logic [3:0]     template_channel_lower;
	logic [4:0]     template_channel_upper;
	int             num_errors = 0;
	int             cmp_count = 0;
	localparam logic [5:0] OFS [6] = '{OFS_AAOS_LOWER, OFS_GCFG_LOWER, OFS_TSEL_LOWER,
		OFS_AAOS_UPPER, OFS_GCFG_UPPER, OFS_TSEL_UPPER};

	lbgc_bank_global_config u_dut (
		.clock                  (clock),
		.srst                   (srst),
		.clk_en                 (clk_en),
		.host_req               (host_req),
		.host_rdata             (host_rdata),
		.host_rvalid            (host_rvalid),
		.loss_detect            (loss_detect),
		.output_enable_pin      (output_enable_pin),
		.chan_cfg               (chan_cfg),
		.send_all_ones          (send_all_ones),
		.send_alarm_sys         (send_alarm_sys),
		.short_protect_off      (short_protect_off),
		.ami_select             (ami_select),
		.atten_deep             (atten_deep),
		.atten_in_rx            (atten_in_rx),
		.atten_on               (atten_on),
		.rx_match_active        (rx_match_active),
		.rx_internal_term       (rx_internal_term),
		.bw_code_lower          (bw_code_lower),
		.bw_code_upper          (bw_code_upper),
		.template_channel_lower (template_channel_lower),
		.template_channel_upper (template_channel_upper),
		.cal_running            (cal_running),
		.cal_status             (cal_status)
	);

	always #10 clock = ~clock;

	task automatic end_of_test;
		$display("Compares %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobes last one cycle and change only at the falling edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		host_req = '{1'b1, 1'b0, a, d};
		@(negedge clock);
		host_req.wr = 1'b0;
	endtask

	task automatic rdck(input logic [5:0] a, input logic [7:0] exp);
		@(negedge clock);
		host_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clock);
		host_req.rd = 1'b0;
		check({host_rvalid, 7'h00, host_rdata}, {1'b1, 7'h00, exp});
	endtask

	// Pin inputs need two sync stages plus the output register
	task automatic settle;
		repeat (4) @(negedge clock);
	endtask

	initial begin
		int n;
		repeat (20) @(negedge clock);
		srst = 1'b0;
		foreach (OFS[i]) rdck(OFS[i], 8'h00);
		foreach (OFS[i]) begin
			wr(OFS[i], 8'h5a ^ 8'(i));
			rdck(OFS[i], 8'h5a ^ 8'(i));
			wr(OFS[i], 8'h00);
		end
		wr(6'h3f, 8'hff);
		rdck(6'h3f, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(OFS_TSEL_LOWER, {k[1:0], 6'(k)});
			wr(OFS_TSEL_UPPER, {~k[1:0], 6'(k)});
			settle;
			check({12'h000, template_channel_lower}, 16'(k + 1));
			check({11'h000, template_channel_upper}, 16'(k + 9));
			check({12'h000, bw_code_upper, bw_code_lower}, {12'h000, ~2'(k), 2'(k)});
		end
		wr(OFS_TSEL_LOWER, 8'h00);
		wr(OFS_TSEL_UPPER, 8'h00);
		loss_detect = 16'hffff;
		wr(OFS_GCFG_LOWER, 8'h79);
		settle;
		check(send_alarm_sys, 16'h00ff);
		check(short_protect_off, 16'h00ff);
		check(ami_select, 16'h00ff);
		check(atten_deep, 16'h00ff);
		check(atten_on, 16'h00ff);
		wr(OFS_GCFG_LOWER, 8'h00);
		wr(OFS_GCFG_UPPER, 8'h79);
		chan_cfg = {7{16'h0a5c}};
		settle;
		check(ami_select, 16'hff5c);
		check(send_alarm_sys, 16'hff5c);
		check(atten_deep, 16'hff5c);
		wr(OFS_GCFG_UPPER, 8'h01);
		wr(OFS_GCFG_LOWER, 8'h02);
		settle;
		check(atten_in_rx, 16'h00ff);
		check(atten_on, 16'hff5c);
		wr(OFS_GCFG_LOWER, 8'h80);
		wr(OFS_TSEL_UPPER, 8'h20);
		settle;
		check(rx_internal_term, 16'h00ff);
		check(rx_match_active, 16'h005c);
		output_enable_pin = 1'b1;
		settle;
		check(rx_match_active, 16'hff5c);
		wr(OFS_AAOS_LOWER, 8'h81);
		wr(OFS_AAOS_UPPER, 8'h01);
		settle;
		check(send_all_ones, 16'h0181);
		loss_detect = 16'h0100;
		settle;
		check(send_all_ones, 16'h0100);
		wr(OFS_GCFG_UPPER, 8'h00);
		wr(OFS_GCFG_LOWER, 8'h04);
		settle;
		check({14'h0000, cal_running, cal_status}, 16'h0000);
		wr(OFS_GCFG_LOWER, 8'h00);
		wr(OFS_GCFG_UPPER, 8'h04);
		// Software side waits the settling time before triggering
		repeat (CAL_CYCLES) @(negedge clock);
		wr(OFS_GCFG_LOWER, 8'h04);
		n = 0;
		while (cal_status !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check({15'h0000, cal_status}, 16'h0001);
		check({15'h0000, cal_running}, 16'h0000);
		wr(OFS_GCFG_LOWER, 8'h00);
		settle;
		check({15'h0000, cal_status}, 16'h0000);
		end_of_test;
	end

	// Whole run is about 700 cycles; this cuts off a hang
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_of_test;
	end
endmodule

bind lbgc_bank_global_config lbgc_chk u_chk (
	.clock                  (clock),
	.srst                   (srst),
	.clk_en                 (clk_en),
	.host_req               (host_req),
	.host_rdata             (host_rdata),
	.host_rvalid            (host_rvalid),
	.loss_detect            (loss_detect),
	.output_enable_pin      (output_enable_pin),
	.chan_cfg               (chan_cfg),
	.send_all_ones          (send_all_ones),
	.send_alarm_sys         (send_alarm_sys),
	.template_channel_lower (template_channel_lower),
	.template_channel_upper (template_channel_upper),
	.cal_running            (cal_running),
	.cal_status             (cal_status)
);
